// [icg_pkg.sv]
// Constants for the internal clock generator tuning block
package icg_pkg;

  // Register indices; byte address is four times the index
  localparam int unsigned ADDR_W        = 10;
  localparam logic [7:0]  IDX_CTRL      = 8'h36;
  localparam logic [7:0]  IDX_MULT      = 8'h37;
  localparam logic [7:0]  IDX_TRIM      = 8'h38;
  localparam logic [7:0]  IDX_DIV       = 8'h39;
  localparam logic [7:0]  IDX_STAGE     = 8'h3A;

  // Control register fields
  localparam int unsigned CTRL_WAKE_BIT   = 0;
  localparam int unsigned CTRL_STABLE_BIT = 2;
  localparam int unsigned CTRL_ENABLE_BIT = 3;

  // Values after reset
  localparam logic        ENABLE_RESET  = 1'b1;
  localparam logic [6:0]  MULT_RESET    = 7'h15;
  localparam logic [7:0]  TRIM_RESET    = 8'h80;
  localparam logic [3:0]  DIV_RESET     = 4'h5;
  localparam logic [7:0]  STAGE_RESET   = 8'hC0;

  // Capacitor array and trim
  localparam logic [9:0]  CAP_FIXED     = 10'h180;
  localparam int unsigned TRIM_STEP_PCT_X1000 = 195;
  localparam logic [15:0] FACTORY_TRIM_ADDR   = 16'h7FEF;

  // Loop filter and bus clock divide
  localparam logic [3:0]  DIV_TOP       = 4'hF;
  localparam logic [7:0]  STAGE_TOP     = 8'hFF;
  localparam logic [7:0]  STAGE_HALF    = 8'h80;
  localparam int unsigned STABLE_BAND_INV = 20;
  localparam logic [1:0]  BUS_TICK_LAST = 2'h3;

  // Timing: one correction spans four base clock periods
  localparam int unsigned SYS_FREQ_HZ   = 25000000;
  localparam int unsigned BASE_FREQ_HZ  = 307200;
  localparam int unsigned BASE_PER_CORR = 4;
  localparam int unsigned CORR_CYCLES_DEF =
    (SYS_FREQ_HZ * BASE_PER_CORR) / BASE_FREQ_HZ;

endpackage

// [dco_ticker.sv]
// Digitally controlled oscillator model: half-period tick generator
`timescale 1ns/1ps
module dco_ticker #(
  parameter int unsigned PERIOD_SHIFT = 4
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // Operating point
  input  wire logic       run,
  input  wire logic [3:0] div,
  input  wire logic [7:0] stage,
  // Half-period pulse
  output logic            tick
);
  typedef struct packed {
    logic [23:0] cnt;
    logic        tick;
  } dco_s;

  dco_s s_r;
  dco_s s_nxt;
  logic [23:0] half_len;

  always_comb begin
    // Period grows as two^div times stage
    half_len = (24'(stage) << div) >> PERIOD_SHIFT;
    if (half_len == 24'h0) begin
      half_len = 24'h1;
    end
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (!run) begin
      // Restart from current operating point on next run
      s_nxt.cnt = 24'h0;
    end else if (s_r.cnt >= half_len - 24'h1) begin
      s_nxt.cnt  = 24'h0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 24'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
endmodule

// [icg_core.sv]
// Internal clock generator: registers, loop filter and clock outputs
`timescale 1ns/1ps
module icg_core #(
  parameter int unsigned CORR_CYCLES  = icg_pkg::CORR_CYCLES_DEF,
  parameter int unsigned BASE_K       = 64,
  parameter int unsigned PERIOD_SHIFT = 4
) (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       arst_n,
  // Avalon-MM slave
  input  wire logic [icg_pkg::ADDR_W-1:0] address,
  input  wire logic                       read,
  input  wire logic                       write,
  input  wire logic [31:0]                writedata,
  output logic      [31:0]                readdata,
  output logic                            waitrequest,
  // Processor state and factory trim
  input  wire logic                       wait_mode,
  input  wire logic                       stop_mode,
  input  wire logic                       factory_trim_valid,
  input  wire logic [7:0]                 factory_trim,
  // Clock outputs and wake request
  output logic                            osc_clock_out,
  output logic                            main_clock_out,
  output logic                            wake_req
);
  import icg_pkg::*;

  typedef struct packed {
    logic        wr;
    logic [31:0] rdata;
    logic        en;
    logic        wake_en;
    logic [6:0]  mult;
    logic [7:0]  trim;
    logic [3:0]  div;
    logic [7:0]  stage;
    logic        stable;
    logic [15:0] corr_cnt;
    logic        trim_done;
    logic        osc;
    logic        main;
    logic [1:0]  main_cnt;
    logic        wake;
  } icg_s;

  icg_s s_r;
  icg_s s_nxt;

  logic        run;
  logic        tick;
  logic        corr_tick;
  logic        wr_take;
  logic        rd_take;
  logic [23:0] period_now;
  logic [23:0] period_goal;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    addr_hit = (a == {idx, 2'b00});
  endfunction

  function automatic logic [23:0] cur_period(input logic [3:0] d, input logic [7:0] st);
    cur_period = 24'(st) << d;
  endfunction

  // Target in stage units: capacitor size scaled, divided by multiplier
  function automatic logic [23:0] goal_period(input logic [7:0] tr, input logic [6:0] n);
    logic [23:0] cap;
    logic [23:0] nn;
    cap = 24'(CAP_FIXED) + 24'(tr);
    nn  = (n == 7'h0) ? 24'h1 : 24'(n);
    goal_period = 24'((cap * 24'(BASE_K)) / nn);
  endfunction

  function automatic logic in_band(input logic [23:0] p, input logic [23:0] t);
    logic [23:0] diff;
    diff    = (p > t) ? p - t : t - p;
    in_band = (32'(diff) * 32'(STABLE_BAND_INV)) <= 32'(t);
  endfunction

  assign run         = s_r.en && !stop_mode;
  assign wr_take     = write && !s_r.wr;
  assign rd_take     = read && s_r.wr;
  assign corr_tick   = run && (32'(s_r.corr_cnt) == CORR_CYCLES - 1);
  assign period_now  = cur_period(s_r.div, s_r.stage);
  assign period_goal = goal_period(s_r.trim, s_r.mult);

  dco_ticker #(
    .PERIOD_SHIFT (PERIOD_SHIFT)
  ) u_dco (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .run     (run),
    .div     (s_r.div),
    .stage   (s_r.stage),
    .tick    (tick)
  );

  always_comb begin
    s_nxt = s_r;

    // One-cycle answer: waitrequest drops the cycle after a request
    s_nxt.wr = 1'b1;
    if ((read || write) && s_r.wr) begin
      s_nxt.wr = 1'b0;
    end
    if (rd_take) begin
      s_nxt.rdata = 32'h0;
      if (addr_hit(address, IDX_CTRL)) begin
        s_nxt.rdata[CTRL_ENABLE_BIT] = s_r.en;
        s_nxt.rdata[CTRL_STABLE_BIT] = s_r.stable;
        s_nxt.rdata[CTRL_WAKE_BIT]   = s_r.wake_en;
      end else if (addr_hit(address, IDX_MULT)) begin
        s_nxt.rdata[6:0] = s_r.mult;
      end else if (addr_hit(address, IDX_TRIM)) begin
        s_nxt.rdata[7:0] = s_r.trim;
      end else if (addr_hit(address, IDX_DIV)) begin
        s_nxt.rdata[3:0] = s_r.div;
      end else if (addr_hit(address, IDX_STAGE)) begin
        s_nxt.rdata[7:0] = s_r.stage;
      end
    end

    // Factory trim taken once after reset release
    if (!s_r.trim_done) begin
      s_nxt.trim_done = 1'b1;
      if (factory_trim_valid) begin
        s_nxt.trim = factory_trim;
      end
    end

    // Register writes
    if (wr_take) begin
      if (addr_hit(address, IDX_CTRL)) begin
        s_nxt.en      = writedata[CTRL_ENABLE_BIT];
        s_nxt.wake_en = writedata[CTRL_WAKE_BIT];
      end else if (addr_hit(address, IDX_MULT)) begin
        s_nxt.mult   = writedata[6:0];
        s_nxt.stable = 1'b0;
      end else if (addr_hit(address, IDX_TRIM)) begin
        s_nxt.trim   = writedata[7:0];
        s_nxt.stable = 1'b0;
      end else if (addr_hit(address, IDX_DIV) && !s_r.en) begin
        s_nxt.div = writedata[3:0];
      end else if (addr_hit(address, IDX_STAGE) && !s_r.en) begin
        s_nxt.stage = writedata[7:0];
      end
    end

    if (!run) begin
      // Halted: outputs low, bus divide and correction counters and stable flag cleared, operating point and other registers retained
      s_nxt.osc      = 1'b0;
      s_nxt.main     = 1'b0;
      s_nxt.main_cnt = 2'h0;
      s_nxt.corr_cnt = 16'h0;
      s_nxt.stable   = 1'b0;
    end else begin
      if (tick) begin
        s_nxt.osc      = !s_r.osc;
        s_nxt.main_cnt = s_r.main_cnt + 2'h1;
        // Bus clock is the internal clock divided by four
        if (s_r.main_cnt == BUS_TICK_LAST) begin
          s_nxt.main = !s_r.main;
        end
      end
      if (corr_tick) begin
        s_nxt.corr_cnt = 16'h0;
        // Loop filter: one step toward the target period
        if (period_now < period_goal) begin
          if (s_r.stage == STAGE_TOP && s_r.div != DIV_TOP) begin
            s_nxt.stage = STAGE_HALF;
            s_nxt.div   = s_r.div + 4'h1;
          end else if (s_r.stage != STAGE_TOP) begin
            s_nxt.stage = s_r.stage + 8'h1;
          end
        end else if (period_now > period_goal) begin
          if (s_r.stage < STAGE_HALF && s_r.div != 4'h0) begin
            s_nxt.stage = {s_r.stage[6:0], 1'b0};
            s_nxt.div   = s_r.div - 4'h1;
          end else if (s_r.stage > 8'h1) begin
            s_nxt.stage = s_r.stage - 8'h1;
          end
        end
        s_nxt.stable = in_band(period_now, period_goal);
      end else begin
        s_nxt.corr_cnt = s_r.corr_cnt + 16'h1;
      end
    end

    // Wake request while waiting once the clock is usable
    s_nxt.wake = wait_mode && s_r.wake_en && s_r.stable && s_r.en;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_r           <= '0;
      s_r.wr        <= 1'b1;
      s_r.en        <= ENABLE_RESET;
      s_r.mult      <= MULT_RESET;
      s_r.trim      <= TRIM_RESET;
      s_r.div       <= DIV_RESET;
      s_r.stage     <= STAGE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign readdata       = s_r.rdata;
  assign waitrequest    = s_r.wr;
  assign osc_clock_out  = s_r.osc;
  assign main_clock_out = s_r.main;
  assign wake_req       = s_r.wake;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  a_stage_wr_open: assert property (
    (wr_take && addr_hit(address, IDX_STAGE) && !s_r.en && !stop_mode)
      |=> (s_r.stage == $past(writedata[7:0])))
    else $error("stage write while disabled was lost");

  a_div_wr_locked: assert property (
    (wr_take && addr_hit(address, IDX_DIV) && s_r.en && !corr_tick)
      |=> $stable(s_r.div))
    else $error("divider changed by a write while enabled");

  a_freeze_off: assert property (
    (!s_r.en && !wr_take) |=> ($stable(s_r.div) && $stable(s_r.stage)))
    else $error("operating point moved while disabled");

  a_stop_clocks_low: assert property (
    stop_mode |=> (!osc_clock_out && !main_clock_out))
    else $error("clock output high during stop");

  a_stop_keeps_regs: assert property (
    (stop_mode && !wr_take) |=>
      ($stable(s_r.trim) && $stable(s_r.mult) && $stable(s_r.div)
       && $stable(s_r.stage) && $stable(s_r.en)))
    else $error("register changed across stop");

  a_stop_unstable: assert property (
    stop_mode ##1 !stop_mode |-> !s_r.stable)
    else $error("stable flag kept through stop");

  a_stable_band: assert property (
    $rose(s_r.stable) |-> $past(in_band(period_now, period_goal)))
    else $error("stable set outside five percent band");

  a_wait_runs: assert property (
    (wait_mode && run && tick) |=> (osc_clock_out != $past(osc_clock_out)))
    else $error("oscillator halted in wait mode");

  a_bus_divide: assert property (
    (run && tick && s_r.main_cnt != BUS_TICK_LAST) |=> $stable(main_clock_out))
    else $error("bus clock toggled off the divide by four");
endmodule

// [clk_consumer.sv]
// Clock consumer model counting generator output edges
`timescale 1ns/1ps
module clk_consumer (
  // Generator clocks
  input  wire logic osc_clock_out,
  input  wire logic main_clock_out,
  // Edge counts
  output int        osc_rises,
  output int        main_rises
);
  int osc_cnt  = 0;
  int main_cnt = 0;

  always @(posedge osc_clock_out) begin
    osc_cnt <= osc_cnt + 1;
  end
  always @(posedge main_clock_out) begin
    main_cnt <= main_cnt + 1;
  end

  assign osc_rises  = osc_cnt;
  assign main_rises = main_cnt;
endmodule

// [internal_clock_gen_tuning_tb.sv]
// Testbench for the internal clock generator tuning block
`timescale 1ns/1ps
module internal_clock_gen_tuning_tb;
  import icg_pkg::*;
  logic              clk_sys;
  logic              arst_n;
  logic              read;
  logic              write;
  logic              wait_mode;
  logic              stop_mode;
  logic              factory_trim_valid;
  logic [7:0]        factory_trim;
  logic [ADDR_W-1:0] address;
  logic [31:0]       writedata;
  logic [31:0]       readdata;
  logic [31:0]       rd;
  logic [7:0]        trim_copy;
  logic              waitrequest;
  logic              osc_clock_out;
  logic              main_clock_out;
  logic              wake_req;
  int                osc_rises;
  int                main_rises;
  int                bad_count;
  int                samples_checked;

  icg_core #(.CORR_CYCLES(64), .BASE_K(64), .PERIOD_SHIFT(8)) dut_u (
    .clk_sys, .arst_n, .address, .read, .write, .writedata, .readdata, .waitrequest,
    .wait_mode, .stop_mode, .factory_trim_valid, .factory_trim,
    .osc_clock_out, .main_clock_out, .wake_req
  );
  clk_consumer cons_u (.osc_clock_out, .main_clock_out, .osc_rises, .main_rises);

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // One Avalon transfer; holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    address <= {idx, 2'b00};
    read <= !wr;
    write <= wr;
    writedata <= wd;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      bad_count++;
      final_report();
    end
    @(posedge clk_sys);
  endtask

  task automatic do_reset(input logic v);
    arst_n <= 1'b0;
    factory_trim_valid <= v;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic reset_scn();
    bus(1'b0, IDX_CTRL, 32'h0);
    chk("ctrl", rd, 32'h00000008);
    bus(1'b0, IDX_MULT, 32'h0);
    chk("mult", rd, 32'h00000015);
    bus(1'b0, IDX_TRIM, 32'h0);
    chk("trim", rd, 32'h00000080);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", rd, 32'h0);
  endtask

  task automatic settle_scn();
    int n;
    bus(1'b1, IDX_CTRL, 32'h00000009);
    n = 0;
    do begin
      bus(1'b0, IDX_CTRL, 32'h0);
      n++;
    end while (rd[CTRL_STABLE_BIT] !== 1'b1 && n < 8000);
    chk("stable", rd[CTRL_STABLE_BIT], 32'h1);
    if (rd[CTRL_STABLE_BIT] !== 1'b1) begin
      final_report();
    end
  endtask

  task automatic wait_scn();
    int o0;
    int m0;
    int d_o;
    int d_m;
    o0 = osc_rises;
    m0 = main_rises;
    wait_mode <= 1'b1;
    repeat (400) @(posedge clk_sys);
    d_o = osc_rises - o0;
    d_m = main_rises - m0;
    chk("osc_in_wait", d_o > 10, 32'h1);
    chk("main_ratio", (d_o - 4 * d_m) inside {[-4:4]}, 32'h1);
    chk("wake_req", wake_req, 32'h1);
    wait_mode <= 1'b0;
    @(posedge clk_sys);
    // Low-power wait: slowest multiplier first
    bus(1'b1, IDX_MULT, 32'h00000001);
    o0 = osc_rises;
    wait_mode <= 1'b1;
    repeat (200) @(posedge clk_sys);
    chk("osc_slow_wait", (osc_rises - o0) > 2, 32'h1);
    chk("wake_unstable", wake_req, 32'h0);
    wait_mode <= 1'b0;
    bus(1'b1, IDX_MULT, 32'h00000015);
  endtask

  task automatic stop_scn();
    int err_x1000;
    // Measured error: base clock 0.78 percent fast
    err_x1000 = 780;
    trim_copy = TRIM_RESET + 8'(err_x1000 / TRIM_STEP_PCT_X1000);
    bus(1'b1, IDX_TRIM, {24'h0, trim_copy});
    stop_mode <= 1'b1;
    repeat (3) @(posedge clk_sys);
    repeat (8) begin
      @(negedge clk_sys);
      chk("osc_stop", osc_clock_out, 32'h0);
      chk("main_stop", main_clock_out, 32'h0);
    end
    @(posedge clk_sys);
    stop_mode <= 1'b0;
    bus(1'b0, IDX_TRIM, 32'h0);
    chk("trim_kept", rd, 32'h00000084);
    bus(1'b0, IDX_MULT, 32'h0);
    chk("mult_kept", rd, 32'h00000015);
    bus(1'b0, IDX_CTRL, 32'h0);
    chk("unstable", rd[CTRL_STABLE_BIT], 32'h0);
  endtask

  task automatic preload_scn();
    logic [3:0] d;
    logic [8:0] s;
    d = 4'h2;
    s = 9'h188;
    bus(1'b1, IDX_CTRL, 32'h0);
    // Stage over range: halve it, bump divider
    if (s > 9'h0FF) begin
      s = s >> 1;
      d = d + 4'h1;
    end
    // Out-of-range divider (above 9) falls back to 9
    if (d > 4'h9) begin
      d = 4'h9;
    end
    bus(1'b1, IDX_DIV, {28'h0, d});
    bus(1'b1, IDX_STAGE, {24'h0, s[7:0]});
    bus(1'b0, IDX_DIV, 32'h0);
    chk("div_wr", rd, {28'h0, d});
    bus(1'b0, IDX_STAGE, 32'h0);
    chk("stage_wr", rd, {24'h0, s[7:0]});
    bus(1'b1, IDX_CTRL, 32'h00000008);
    bus(1'b0, IDX_DIV, 32'h0);
    chk("div_start", rd, 32'h00000003);
    bus(1'b0, IDX_STAGE, 32'h0);
    chk("stage_start", rd[7:0] inside {[8'hC3:8'hC5]}, 32'h1);
    bus(1'b1, IDX_DIV, 32'h0000000E);
    bus(1'b0, IDX_DIV, 32'h0);
    chk("div_locked", rd, 32'h00000003);
    // Double the period: same stage, divider one up
    bus(1'b1, IDX_CTRL, 32'h0);
    bus(1'b1, IDX_DIV, {28'h0, d + 4'h1});
    bus(1'b0, IDX_DIV, 32'h0);
    chk("div_double", rd, 32'h00000004);
    bus(1'b0, IDX_STAGE, 32'h0);
    chk("stage_same", rd, 32'h000000C4);
  endtask

  initial begin
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    wait_mode = 1'b0;
    stop_mode = 1'b0;
    factory_trim_valid = 1'b0;
    factory_trim = 8'h7A;
    arst_n = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    do_reset(1'b0);
    reset_scn();
    settle_scn();
    wait_scn();
    stop_scn();
    preload_scn();
    // Second reset mid-run with a factory trim present
    do_reset(1'b1);
    bus(1'b0, IDX_TRIM, 32'h0);
    chk("factory_trim", rd, 32'h0000007A);
    // Restore the saved trim copy after reset
    bus(1'b1, IDX_TRIM, {24'h0, trim_copy});
    bus(1'b0, IDX_TRIM, 32'h0);
    chk("trim_restore", rd, 32'h00000084);
    final_report();
  end
endmodule
